// [src/uir_pkg.sv]
// Shared constants for the USB interrupt and endpoint reset block.
package uir_pkg;
   // Register offsets, byte addresses on the local register port.
   localparam logic [7:0] UIR_OFF_IRQ_UNMASK = 8'h10;
   localparam logic [7:0] UIR_OFF_IRQ_MASKOFF = 8'h14;
   localparam logic [7:0] UIR_OFF_IRQ_MASK_VIEW = 8'h18;
   localparam logic [7:0] UIR_OFF_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] UIR_OFF_IRQ_CLEAR = 8'h20;
   localparam logic [7:0] UIR_OFF_EP_FIFO_RESET = 8'h28;
   // Bit positions in the status, mask and clear words.
   localparam int UIR_BIT_ENDPOINT_ZERO = 0;
   localparam int UIR_BIT_SUSPEND = 8;
   localparam int UIR_BIT_HOST_RESUME = 9;
   localparam int UIR_BIT_EXT_RESUME = 10;
   localparam int UIR_BIT_FRAME_START = 11;
   localparam int UIR_BIT_BUS_RESET_DONE = 12;
   localparam int UIR_BIT_WAKEUP = 13;
   localparam int UIR_NUM_EP = 4;
   localparam int UIR_NUM_CAUSE = 5;
   // Implemented bits of the status word; endpoint bits are not clearable there.
   localparam logic [13:0] UIR_STATUS_IMPL = 14'h3F0F;
   localparam logic [13:0] UIR_EVENT_BITS = 14'h3F00;
   localparam logic [13:0] UIR_MASK_IMPL = 14'h2F0F;
   localparam logic [13:0] UIR_MASK_RESET = 14'h0200;
   localparam logic [13:0] UIR_STATUS_RESET = 14'h0000;
   localparam logic [3:0] UIR_EP_RESET_INIT = 4'h0;
   // Timing: idle time to suspend and length of driven resume signalling.
   localparam int UIR_CLK_HZ = 40_000_000;
   localparam int UIR_SUSPEND_IDLE_MS = 3;
   localparam int UIR_SUSPEND_CYC = UIR_CLK_HZ / 1000 * UIR_SUSPEND_IDLE_MS;
   localparam int UIR_RESUME_DRIVE_MS = 10;
   localparam int UIR_RESUME_CYC = UIR_CLK_HZ / 1000 * UIR_RESUME_DRIVE_MS;
   localparam int UIR_CNT_W = 20;
   localparam logic [UIR_CNT_W-1:0] UIR_CNT_ONE = 20'h00001;
   localparam logic [3:0] UIR_EP_HOLD_CYC = 4'h8;
endpackage

// [src/uir_reg_if.sv]
// Register port between firmware agent and the USB interrupt logic.
`timescale 1ns/1ps
`default_nettype none
interface uir_reg_if (
   input wire logic i_clk_sys
);
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic rvalid;
   logic irq;

   modport dev (input wr, input rd, input addr, input wdata,
      output rdata, output rvalid, output irq);
   modport fw (output wr, output rd, output addr, output wdata,
      input rdata, input rvalid, input irq);
endinterface
`default_nettype wire

// [src/uir_device.sv]
// USB device interrupt flags, mask, clear and endpoint FIFO reset logic.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01 - Endpoint flag set by any cause bit.
// R02 - Endpoint flag sticks until cause bit cleared.
// R03 - Three ms idle sets suspend flag, suspends.
// R04 - Host resume signalling sets resume flag.
// R05 - Firmware clears undefined resume flag first.
// R06 - External resume edge flagged only while suspended.
// R07 - External resume plus wake enable drives resume.
// R08 - Each start-of-frame token sets frame flag.
// R09 - Bus reset end flagged; firmware prepares endpoint 0.
// R10 - Host resume or reset sets wake-up flag.
// R11 - Firmware clears undefined wake-up flag first.
// R12 - Clear register ones clear event flags.
// R13 - Clear register bit clears bus reset done.
// R14 - Endpoint reset clears FIFO, count, toggle.
// R15 - While reset bit set, pointers held zero.
// R16 - Firmware clears reset bit; flags untouched.
// R17 - Endpoint reset advised after halt removal.
// R18 - Unmask writes of one enable, zero ignored.
// R19 - Host resume mask enabled out of reset.
// R20 - Interrupt when flag and mask both set.
module uir_device #(
   parameter int SUSPEND_CYC = uir_pkg::UIR_SUSPEND_CYC,
   parameter int RESUME_CYC = uir_pkg::UIR_RESUME_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   uir_reg_if.dev bus,
   input wire logic i_bus_activity,
   input wire logic i_host_resume,
   input wire logic i_frame_start,
   input wire logic i_bus_reset_end,
   input wire logic i_ext_resume_req,
   input wire logic i_remote_wake_enable,
   input wire logic [uir_pkg::UIR_NUM_EP*uir_pkg::UIR_NUM_CAUSE-1:0] i_ep_cause,
   output logic o_suspended,
   output logic o_resume_drive,
   output logic [uir_pkg::UIR_NUM_EP-1:0] o_ep_fifo_clear,
   output logic [uir_pkg::UIR_NUM_EP-1:0] o_ep_toggle_data0
);
   import uir_pkg::*;

   // Counter limits at the counter's width. Both defaults fit in UIR_CNT_W bits;
   // a larger override would wrap, so keep the clock rate and the times consistent.
   localparam logic [UIR_CNT_W-1:0] SUSP_LIM = UIR_CNT_W'(SUSPEND_CYC);
   localparam logic [UIR_CNT_W-1:0] RSM_LIM = UIR_CNT_W'(RESUME_CYC);

   // All state of the block lives in one packed word, filled by one process
   // and registered by another.
   typedef struct packed {
      // Flag, mask and endpoint reset registers seen by firmware.
      logic [13:0] status;
      logic [13:0] mask;
      logic [3:0] ep_reset;
      // Timers for suspend detection and for driven resume signalling.
      logic [UIR_CNT_W-1:0] idle_cnt;
      logic [UIR_CNT_W-1:0] rsm_cnt;
      logic suspended;
      logic resume_drive;
      // Two-stage synchroniser for the external request, then an edge stage.
      logic ext_s1;
      logic ext_s2;
      logic ext_s3;
      // Read port and interrupt line.
      logic [31:0] rdata;
      logic rvalid;
      logic irq;
   } uir_dev_state_t;

   // Current and next state, plus helpers that only the next-state process uses.
   uir_dev_state_t state_reg;
   uir_dev_state_t state_next;
   logic [3:0] ep_any;
   logic [13:0] set_vec;
   logic [13:0] clr_vec;
   logic ext_edge;

   // Reduce each endpoint's five cause bits to one level.
   // Causes are levels held by the endpoint logic, so no edge is needed here.
   always_comb begin
      for (int e = 0; e < UIR_NUM_EP; e++) begin
         ep_any[e] = |i_ep_cause[e*UIR_NUM_CAUSE +: UIR_NUM_CAUSE]; // R01
      end
   end

   // Next-state logic for flags, mask, suspend tracking and register reads.
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      // Only the second and third stages feed the edge test; the first stays private.
      // The pin idles low like the reset value of the stages, so reset makes no false edge.
      state_next.ext_s1 = i_ext_resume_req;
      state_next.ext_s2 = state_reg.ext_s1;
      state_next.ext_s3 = state_reg.ext_s2;
      ext_edge = state_reg.ext_s2 & ~state_reg.ext_s3;

      // Event sets; the endpoint bits mirror the causes, so they stay sticky.
      set_vec = 14'h0000;
      set_vec[UIR_BIT_HOST_RESUME] = i_host_resume; // R04
      set_vec[UIR_BIT_FRAME_START] = i_frame_start; // R08
      set_vec[UIR_BIT_BUS_RESET_DONE] = i_bus_reset_end; // R09
      set_vec[UIR_BIT_WAKEUP] = i_host_resume | i_bus_reset_end; // R10
      set_vec[UIR_BIT_EXT_RESUME] = ext_edge & state_reg.suspended; // R06

      // Suspend detection: count idle cycles, flag once at the limit.
      // The counter stops while suspended, so one idle period gives one flag;
      // activity must be seen before another idle period can start.
      if (i_bus_activity) begin
         state_next.idle_cnt = '0;
         state_next.suspended = 1'b0;
      end else if (!state_reg.suspended) begin
         if (state_reg.idle_cnt >= SUSP_LIM - UIR_CNT_ONE) begin
            state_next.suspended = 1'b1; // R03
            set_vec[UIR_BIT_SUSPEND] = 1'b1; // R03
            state_next.idle_cnt = '0;
         end else begin
            state_next.idle_cnt = state_reg.idle_cnt + UIR_CNT_ONE;
         end
      end

      // Remote wake-up: drive resume for a fixed time after an external request.
      // A second request while driving is ignored; the drive is not extended.
      if (state_reg.resume_drive) begin
         if (state_reg.rsm_cnt >= RSM_LIM - UIR_CNT_ONE) begin
            state_next.resume_drive = 1'b0;
            state_next.rsm_cnt = '0;
         end else begin
            state_next.rsm_cnt = state_reg.rsm_cnt + UIR_CNT_ONE;
         end
      end else if (set_vec[UIR_BIT_EXT_RESUME] && i_remote_wake_enable) begin
         state_next.resume_drive = 1'b1; // R07
         state_next.rsm_cnt = '0;
      end

      // Register writes.
      // Unknown offsets are ignored, and the status offset is read-only, so a
      // write there changes nothing.
      clr_vec = 14'h0000;
      if (bus.wr) begin
         unique case (bus.addr)
            UIR_OFF_IRQ_UNMASK: begin
               state_next.mask = state_reg.mask | (bus.wdata[13:0] & UIR_MASK_IMPL); // R18
            end
            UIR_OFF_IRQ_MASKOFF: begin
               state_next.mask = state_reg.mask & ~bus.wdata[13:0];
            end
            UIR_OFF_IRQ_CLEAR: begin
               clr_vec = bus.wdata[13:0] & UIR_EVENT_BITS; // R12 R13
            end
            UIR_OFF_EP_FIFO_RESET: begin
               state_next.ep_reset = bus.wdata[3:0]; // R16
            end
            default: begin
            end
         endcase
      end

      // Event flags: a set in the same cycle as a clear wins.
      // Endpoint bits are not stored; they follow their causes, which firmware
      // clears through each endpoint's control register.
      state_next.status[13:8] = ((state_reg.status[13:8] & ~clr_vec[13:8])
         | set_vec[13:8]) & UIR_STATUS_IMPL[13:8]; // R12
      state_next.status[3:0] = ep_any; // R02
      state_next.status[7:4] = 4'h0;

      // Register reads answer one cycle later; unmapped offsets read zero.
      // The write-only clear offset reads zero like any unmapped one.
      if (bus.rd) begin
         state_next.rvalid = 1'b1;
         unique case (bus.addr)
            UIR_OFF_IRQ_MASK_VIEW: state_next.rdata = {18'h00000, state_reg.mask};
            UIR_OFF_IRQ_STATUS: state_next.rdata = {18'h00000, state_reg.status};
            UIR_OFF_EP_FIFO_RESET: state_next.rdata = {28'h0000000, state_reg.ep_reset};
            default: state_next.rdata = 32'h00000000;
         endcase
      end

      // Irq is taken from the next state so it rises with the flag register and
      // drops in the cycle a clear lands, not one cycle after.
      state_next.irq = |(state_next.status & state_next.mask); // R20
   end

   // State register; undefined-after-reset flags come up cleared here.
   // Reset is synchronous; mask, status and endpoint reset values come from the package, all other fields reset to zero.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= '0;
         state_reg.mask <= UIR_MASK_RESET; // R19
         state_reg.status <= UIR_STATUS_RESET;
         state_reg.ep_reset <= UIR_EP_RESET_INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   // Every output is a plain copy of a state flop.
   assign bus.rdata = state_reg.rdata;
   assign bus.rvalid = state_reg.rvalid;
   assign bus.irq = state_reg.irq;
   assign o_suspended = state_reg.suspended;
   assign o_resume_drive = state_reg.resume_drive;
   // Pointers and toggle are held while the bit stays set; CSR flags are not touched.
   assign o_ep_fifo_clear = state_reg.ep_reset; // R14 R15
   assign o_ep_toggle_data0 = state_reg.ep_reset; // R14
endmodule
`default_nettype wire

// [src/uir_firmware.sv]
// Firmware-side agent that services the USB interrupt and endpoint reset registers.
`timescale 1ns/1ps
`default_nettype none
module uir_firmware (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   uir_reg_if.fw bus,
   input wire logic [13:0] i_irq_enable,
   input wire logic [uir_pkg::UIR_NUM_EP-1:0] i_ep_reset_req,
   output logic o_ready,
   output logic o_ep0_prepare,
   output logic [13:0] o_events,
   output logic o_events_valid,
   output logic o_ep_reset_busy
);
   import uir_pkg::*;

   typedef enum logic [2:0] {
      FW_INIT_CLR = 3'b000,
      FW_INIT_EN = 3'b001,
      FW_IDLE = 3'b010,
      FW_RD_STATUS = 3'b011,
      FW_WAIT_RD = 3'b100,
      FW_ACK = 3'b101,
      FW_EPR_HOLD = 3'b110,
      FW_EPR_CLR = 3'b111
   } uir_fw_mode_t;

   typedef struct packed {
      uir_fw_mode_t mode;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [13:0] seen;
      logic [3:0] hold;
      logic ready;
      logic ep0_prepare;
      logic [13:0] events;
      logic events_valid;
      logic busy;
   } uir_fw_state_t;

   uir_fw_state_t state_reg;
   uir_fw_state_t state_next;

   // Sequencer: one register access per step, strobes last one cycle.
   always_comb begin
      state_next = state_reg;
      state_next.wr = 1'b0;
      state_next.rd = 1'b0;
      state_next.ep0_prepare = 1'b0;
      state_next.events_valid = 1'b0;
      unique case (state_reg.mode)
         FW_INIT_CLR: begin
            // Both flags are undefined after reset, so clear them first.
            state_next.wr = 1'b1;
            state_next.addr = UIR_OFF_IRQ_CLEAR;
            state_next.wdata = 32'h00000000;
            state_next.wdata[UIR_BIT_HOST_RESUME] = 1'b1; // R05
            state_next.wdata[UIR_BIT_WAKEUP] = 1'b1; // R11
            state_next.mode = FW_INIT_EN;
         end
         FW_INIT_EN: begin
            state_next.wr = 1'b1;
            state_next.addr = UIR_OFF_IRQ_UNMASK;
            state_next.wdata = {18'h00000, i_irq_enable};
            state_next.ready = 1'b1;
            state_next.mode = FW_IDLE;
         end
         FW_IDLE: begin
            if (|i_ep_reset_req) begin
               // Used after a halt is lifted on a bulk endpoint.
               state_next.wr = 1'b1; // R17
               state_next.addr = UIR_OFF_EP_FIFO_RESET;
               state_next.wdata = {28'h0000000, i_ep_reset_req};
               state_next.hold = UIR_EP_HOLD_CYC;
               state_next.busy = 1'b1;
               state_next.mode = FW_EPR_HOLD;
            end else if (bus.irq) begin
               state_next.mode = FW_RD_STATUS;
            end
         end
         FW_RD_STATUS: begin
            state_next.rd = 1'b1;
            state_next.addr = UIR_OFF_IRQ_STATUS;
            state_next.mode = FW_WAIT_RD;
         end
         FW_WAIT_RD: begin
            if (bus.rvalid) begin
               state_next.seen = bus.rdata[13:0];
               state_next.events = bus.rdata[13:0];
               state_next.events_valid = 1'b1;
               state_next.mode = FW_ACK;
            end
         end
         FW_ACK: begin
            // Endpoint bits clear through their own control register, not here.
            state_next.wr = 1'b1;
            state_next.addr = UIR_OFF_IRQ_CLEAR;
            state_next.wdata = {18'h00000, state_reg.seen & UIR_EVENT_BITS};
            state_next.ep0_prepare = state_reg.seen[UIR_BIT_BUS_RESET_DONE]; // R09
            state_next.mode = FW_IDLE;
         end
         FW_EPR_HOLD: begin
            if (state_reg.hold == 4'h0) begin
               state_next.mode = FW_EPR_CLR;
            end else begin
               state_next.hold = state_reg.hold - 4'h1;
            end
         end
         FW_EPR_CLR: begin
            state_next.wr = 1'b1; // R16
            state_next.addr = UIR_OFF_EP_FIFO_RESET;
            state_next.wdata = 32'h00000000;
            state_next.busy = 1'b0;
            state_next.mode = FW_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg <= '0;
         state_reg.mode <= FW_INIT_CLR;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.wr = state_reg.wr;
   assign bus.rd = state_reg.rd;
   assign bus.addr = state_reg.addr;
   assign bus.wdata = state_reg.wdata;
   assign o_ready = state_reg.ready;
   assign o_ep0_prepare = state_reg.ep0_prepare;
   assign o_events = state_reg.events;
   assign o_events_valid = state_reg.events_valid;
   assign o_ep_reset_busy = state_reg.busy;
endmodule
`default_nettype wire

// [testbench/uir_props.sv]
// Bus-level assertions for the link between the USB interrupt device and firmware.
`timescale 1ns/1ps
`default_nettype none
module uir_props
   import uir_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_irq
);
   logic [13:0] mask_reg;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // Shadow of the mask, so irq can be judged against what a status read returns.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mask_reg <= UIR_MASK_RESET;
      end else if (i_wr && i_addr == UIR_OFF_IRQ_UNMASK) begin
         mask_reg <= mask_reg | (i_wdata[13:0] & UIR_MASK_IMPL);
      end else if (i_wr && i_addr == UIR_OFF_IRQ_MASKOFF) begin
         mask_reg <= mask_reg & ~i_wdata[13:0];
      end
   end

   a_read_answer: assert property (i_rd |=> i_rvalid)
      else $error("read strobe got no answer");
   a_status_unused: assert property (
      i_rvalid && $past(i_addr) == UIR_OFF_IRQ_STATUS |->
      (i_rdata & ~{18'h0, UIR_STATUS_IMPL}) == 32'h0)
      else $error("status read shows unused bits");
   a_init_clear: assert property ($fell(i_rst) |-> ##[0:2]
      (i_wr && i_addr == UIR_OFF_IRQ_CLEAR && i_wdata[9] && i_wdata[13]))
      else $error("undefined flags not cleared after reset");
   a_ack_match: assert property (
      i_rvalid && $past(i_addr) == UIR_OFF_IRQ_STATUS && i_rdata[13:8] != 6'h0 |->
      ##[0:3] (i_wr && i_addr == UIR_OFF_IRQ_CLEAR && i_wdata[13:8] == i_rdata[13:8]))
      else $error("seen events not acknowledged");
   a_clear_no_ep: assert property (
      i_wr && i_addr == UIR_OFF_IRQ_CLEAR |-> i_wdata[7:0] == 8'h0)
      else $error("clear write touches endpoint bits");
   a_ep_release: assert property (
      i_wr && i_addr == UIR_OFF_EP_FIFO_RESET && i_wdata[3:0] != 4'h0 |->
      ##[5:15] (i_wr && i_addr == UIR_OFF_EP_FIFO_RESET && i_wdata[3:0] == 4'h0))
      else $error("endpoint reset never released");
   a_ep_write_clean: assert property (
      i_wr && i_addr == UIR_OFF_EP_FIFO_RESET |-> i_wdata[31:4] == 28'h0)
      else $error("endpoint reset write has stray bits");
   a_irq_source: assert property (
      i_rvalid && $past(i_addr) == UIR_OFF_IRQ_STATUS |->
      $past(i_irq) == |(i_rdata[13:0] & $past(mask_reg)))
      else $error("irq disagrees with status and mask");

   // The main scenarios the bench must reach.
   c_ep_reset: cover property (i_wr && i_addr == UIR_OFF_EP_FIFO_RESET && i_wdata[3:0] != 4'h0);
   c_suspend_ack: cover property (i_wr && i_addr == UIR_OFF_IRQ_CLEAR && i_wdata[8]);
   c_ext_resume: cover property (i_rvalid && $past(i_addr) == UIR_OFF_IRQ_STATUS && i_rdata[10]);
endmodule
`default_nettype wire

// [testbench/usb_device_irq_and_ep_reset_test.sv]
// Self-checking bench joining the USB interrupt device and its firmware agent.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
   miscompares++; $display("BAD %0t %s", $time, msg); end end
module usb_device_irq_and_ep_reset_test;
   import uir_pkg::*;
   localparam int SUS = 20;
   localparam int RES = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic act = 1'b1;
   logic hres = 1'b0;
   logic sof = 1'b0;
   logic bre = 1'b0;
   logic ext = 1'b0;
   logic wake = 1'b0;
   logic [19:0] cause = 20'h00000;
   logic [3:0] ep_req = 4'h0;
   logic suspended, resume_drive, ready, ep0_prep, ev_valid, ep_busy;
   logic [3:0] fifo_clr;
   logic [3:0] tog0;
   logic [13:0] events;
   logic [13:0] ev;
   logic [3:0] r;
   logic hit;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int drive_cyc = 0;
   int prep_seen = 0;
   int i, k, e, c;
   int unsigned seed = 9;

   uir_reg_if bus (.i_clk_sys(clk));
   uir_device #(.SUSPEND_CYC(SUS), .RESUME_CYC(RES)) i_uir_device (.i_clk_sys(clk),
      .i_rst(rst), .bus(bus), .i_bus_activity(act), .i_host_resume(hres),
      .i_frame_start(sof), .i_bus_reset_end(bre), .i_ext_resume_req(ext),
      .i_remote_wake_enable(wake), .i_ep_cause(cause), .o_suspended(suspended),
      .o_resume_drive(resume_drive), .o_ep_fifo_clear(fifo_clr), .o_ep_toggle_data0(tog0));
   uir_firmware i_uir_firmware (.i_clk_sys(clk), .i_rst(rst), .bus(bus),
      .i_irq_enable(14'h2F0F), .i_ep_reset_req(ep_req), .o_ready(ready),
      .o_ep0_prepare(ep0_prep), .o_events(events), .o_events_valid(ev_valid),
      .o_ep_reset_busy(ep_busy));
   uir_props i_uir_props (.i_clk_sys(clk), .i_rst(rst), .i_wr(bus.wr), .i_rd(bus.rd),
      .i_addr(bus.addr), .i_wdata(bus.wdata), .i_rdata(bus.rdata), .i_rvalid(bus.rvalid),
      .i_irq(bus.irq));

   // Free-running 40 MHz clock.
   always #12.5 clk = ~clk;

   // Cycle budget, resume drive length and prepare pulses; a hang counts as a mismatch.
   always @(posedge clk) begin
      cycles++;
      if (resume_drive === 1'b1) drive_cyc++;
      if (ep0_prep === 1'b1) prep_seen++;
      if (cycles == 20000) begin
         miscompares++;
         $display("BAD %0t cycle budget exhausted", $time);
         give_verdict();
      end
   end

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected status word for each single bus event: frame, host resume, reset end.
   function automatic logic [13:0] ev_of(int kind);
      case (kind)
         0: return 14'h0800;
         1: return 14'h2200;
         default: return 14'h3000;
      endcase
   endfunction

   // Sampling one step after the edge keeps reads clear of that edge's updates.
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_ev(output logic [13:0] val);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (ev_valid !== 1'b1 && n < 200);
      val = (ev_valid === 1'b1) ? events : 14'hXXXX;
   endtask

   task automatic give_verdict();
      $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: reset, init, endpoint flags, bus events, suspend, endpoint reset.
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 50 && ready !== 1'b1; i++) tick(1);
      `CHK(ready, 1'b1, "firmware init")
      tick(3);
      `CHK(bus.irq, 1'b0, "irq idle after init")
      $display("test init done");
      for (k = 0; k < 4; k++) begin
         e = int'(rnd() % 4);
         c = int'(rnd() % 5);
         @(posedge clk);
         cause[e * 5 + c] <= 1'b1;
         wait_ev(ev);
         `CHK(ev, 14'(1 << e), "endpoint flag")
         wait_ev(ev);
         `CHK(ev, 14'(1 << e), "endpoint flag after ack")
         @(posedge clk);
         cause <= 20'h00000;
         tick(6);
         `CHK(bus.irq, 1'b0, "irq after cause cleared")
      end
      $display("test endpoint flags done");
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         case (k)
            0: sof <= 1'b1;
            1: hres <= 1'b1;
            default: bre <= 1'b1;
         endcase
         @(posedge clk);
         {sof, hres, bre} <= 3'h0;
         wait_ev(ev);
         `CHK(ev, ev_of(k), "bus event flags")
         tick(6);
         `CHK(bus.irq, 1'b0, "irq after clear")
         `CHK(events, 14'h0000, "flags gone after ack")
      end
      `CHK(prep_seen, 1, "endpoint zero prepare")
      $display("test bus events done");
      // Two passes: with wake-up enabled resume is driven, without it only flagged.
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         wake <= (k == 0);
         act <= 1'b0;
         wait_ev(ev);
         `CHK(ev, 14'h0100, "suspend flag")
         `CHK(suspended, 1'b1, "suspended")
         tick(4);
         @(posedge clk);
         ext <= 1'b1;
         wait_ev(ev);
         `CHK(ev, 14'h0400, "external resume flag")
         @(posedge clk);
         act <= 1'b1;
         ext <= 1'b0;
         tick(RES + 6);
         `CHK(drive_cyc, RES, "resume drive length")
         `CHK(suspended, 1'b0, "left suspend")
      end
      // Irq is watched on every cycle, since firmware would clear a stray flag quickly.
      @(posedge clk);
      ext <= 1'b1;
      hit = 1'b0;
      for (i = 0; i < 12; i++) begin
         tick(1);
         hit = hit | bus.irq;
      end
      `CHK(hit, 1'b0, "external edge while awake")
      `CHK(drive_cyc, RES, "no drive while awake")
      @(posedge clk);
      ext <= 1'b0;
      $display("test suspend and resume done");
      for (k = 0; k < 2; k++) begin
         r = 4'((rnd() % 15) + 1);
         @(posedge clk);
         ep_req <= r;
         @(posedge clk);
         ep_req <= 4'h0;
         for (i = 0; i < 50 && fifo_clr !== r; i++) tick(1);
         `CHK(fifo_clr, r, "fifo clear while reset set")
         `CHK(tog0, r, "toggle back to data0")
         for (i = 0; i < 50 && fifo_clr !== 4'h0; i++) tick(1);
         `CHK(fifo_clr, 4'h0, "reset released")
         tick(4);
         `CHK(ep_busy, 1'b0, "reset sequence over")
      end
      $display("test endpoint reset done");
      give_verdict();
   end
endmodule
`undef CHK
`default_nettype wire
